// ---- acss_sequencer.sv ----
// Channel scan sequencer: command intake on the link clock, scan engine on core clock.
// Assumes the converter answers conv_start_o with one conv_done_i pulse on clock_i.
`timescale 1ns/100ps
module acss_sequencer #(
  parameter int DLY_UNIT = acss_pkg::DELAY_UNIT_CYC
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire logic                      link_clk_i,
  input  wire logic                      link_rst_i,
  input  wire logic [7:0]                link_cmd_i,
  input  wire logic                      link_cmd_valid_i,
  input  wire acss_pkg::acss_scan_setup_s scan_setup_reg_i,
  input  wire acss_pkg::acss_chmap_t     channel_map_i,
  input  wire logic [7:0]                input_delay_i,
  input  wire logic [7:0]                pin_delay_i,
  input  wire logic                      single_cycle_bit_i,
  input  wire logic                      continuous_single_cycle_bit_i,
  input  wire logic [1:0]                power_down_field_i,
  input  wire logic                      pin_sequencing_bit_i,
  input  wire logic [acss_pkg::PIN_N-1:0] pin_direction_reg_i,
  input  wire logic                      conv_done_i,
  input  wire acss_pkg::acss_data_t      conv_data_i,
  output logic                           conv_start_o,
  output logic [2:0]                     input_select_o,
  output logic [3:0]                     rate_o,
  output logic [1:0]                     power_state_status_o,
  output logic [acss_pkg::CH_N-1:0]      per_channel_ready_flags_o,
  output logic                           data_ready_strobe_n_o,
  output logic                           pin_conflict_error_o,
  output logic                           order_error_o,
  output logic [acss_pkg::PIN_N-1:0]     bias_output_pin_o,
  output acss_pkg::acss_data_arr_t       channel_data_o
);
  import acss_pkg::*;

  // link side: hold the byte and flip a toggle per command
  logic [7:0] hold_q, hold_d;
  logic       tog_q, tog_d;
  always_comb begin
    hold_d = hold_q;
    tog_d  = tog_q;
    if (link_cmd_valid_i) begin
      hold_d = link_cmd_i;
      tog_d  = ~tog_q;
    end
  end
  always_ff @(posedge link_clk_i) begin
    if (link_rst_i) begin
      hold_q <= 8'h00;
      tog_q  <= 1'b0;
    end else begin
      hold_q <= hold_d;
      tog_q  <= tog_d;
    end
  end

  // toggle crossing; the byte is stable long before the synced edge arrives
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= tog_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  acss_cmd_s cmd;
  logic      cmd_ev, cmd_pd, cmd_seq;
  assign cmd     = acss_cmd_s'(hold_q);
  assign cmd_ev  = s2_q ^ s3_q;
  assign cmd_pd  = cmd_ev && cmd.tag == CMD_TAG && cmd.mode == CMD_MODE_PD;
  assign cmd_seq = cmd_ev && cmd.tag == CMD_TAG && cmd.mode == CMD_MODE_SEQ;

  // per-channel checks: order validity and pin sharing with any later channel
  logic [CH_N-1:0] ord_bad, pin_clash, cand;
  acss_state_e     st_q, st_d;
  logic [2:0]      ch_q, ch_d, ord_q, ord_d, base;
  genvar gi;
  for (gi = 0; gi < CH_N; gi++) begin : g_ch
    acss_chmap_s m;
    logic [CH_N-1:0] hit;
    assign m = channel_map_i[gi];
    assign ord_bad[gi] = m.channel_enable_bit && (m.channel_order_field == ORD_BAD_LO
                         || m.channel_order_field == ORD_BAD_HI);
    for (genvar gj = 0; gj < CH_N; gj++) begin : g_pair
      assign hit[gj] = (gj > gi) && m.channel_pin_enable
                       && channel_map_i[gj].channel_pin_enable
                       && m.channel_pin_map == channel_map_i[gj].channel_pin_map;
    end
    assign pin_clash[gi] = |hit;
    // pin maps play no part in choosing channels
    assign cand[gi] = m.channel_enable_bit && !ord_bad[gi]
                      && m.channel_order_field > base;
  end

  // smallest order above the last one visited, lowest index on ties
  logic       nxt_found;
  logic [2:0] nxt_ch, nxt_ord;
  always_comb begin
    nxt_found = 1'b0;
    nxt_ch    = 3'h0;
    nxt_ord   = ORD_BAD_HI;
    for (int i = 0; i < CH_N; i++) begin
      if (cand[i] && channel_map_i[i].channel_order_field < nxt_ord) begin
        nxt_found = 1'b1;
        nxt_ch    = 3'(i);
        nxt_ord   = channel_map_i[i].channel_order_field;
      end
    end
  end

  // scan engine state
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic [1:0]         mode_q, mode_d, pd_q, pd_d, pstat_q, pstat_d;
  logic [3:0]         rate_q, rate_d;
  logic [CH_N-1:0]    rdy_q, rdy_d;
  logic               strobe_n_q, strobe_n_d, start_q, start_d;
  logic               err_pin_q, err_ord_q;
  logic [PIN_N-1:0]   pin_q, pin_d;
  acss_data_arr_t     data_q, data_d;
  logic               idle, running, cfg_bad, go_pin, go_in, cont;
  logic [CNT_W-1:0]   in_load, pin_load;

  assign idle     = st_q == ST_STANDBY || st_q == ST_SLEEP;
  assign running  = !idle;
  assign base     = idle ? ORD_NONE : ord_q;
  assign in_load  = CNT_W'(input_delay_i) * CNT_W'(DLY_UNIT);
  assign pin_load = CNT_W'(pin_delay_i) * CNT_W'(DLY_UNIT);
  assign cont     = !single_cycle_bit_i || continuous_single_cycle_bit_i;
  // every mode but single refuses single-cycle bit zero; the biased scan also refuses bad maps
  assign cfg_bad  = (scan_setup_reg_i.mode != SCAN_SINGLE && !single_cycle_bit_i)
                 || (scan_setup_reg_i.mode == SCAN_BIAS && (err_pin_q || err_ord_q))
                 || scan_setup_reg_i.mode == SCAN_RSVD;

  // next-state logic; a power-down command overrides state, start and strobe, but a finishing result and its ready flag are still stored
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    ord_d = ord_q;
    cnt_d = cnt_q;
    mode_d = mode_q;
    pd_d = pd_q;
    rate_d = rate_q;
    rdy_d = rdy_q;
    data_d = data_q;
    strobe_n_d = 1'b1;
    start_d = 1'b0;
    go_pin = 1'b0;
    go_in = 1'b0;
    case (st_q)
      ST_STANDBY, ST_SLEEP: begin
        if (cmd_seq && !cfg_bad) begin
          mode_d = scan_setup_reg_i.mode;
          pd_d   = power_down_field_i;
          rate_d = cmd.rate;
          rdy_d  = '0;
          if (scan_setup_reg_i.mode == SCAN_SINGLE) begin
            ch_d  = scan_setup_reg_i.input_select;
            go_in = 1'b1;
          end else if (nxt_found) begin
            ch_d   = nxt_ch;
            ord_d  = nxt_ord;
            go_pin = 1'b1;
          end else begin
            st_d = ST_SLEEP;
          end
        end
      end
      ST_PIN_WAIT: begin
        if (cnt_q != '0) cnt_d = cnt_q - CNT_W'(1);
        else go_in = 1'b1;
      end
      ST_IN_WAIT: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          st_d    = ST_CONV;
          start_d = 1'b1;
        end
      end
      ST_CONV: begin
        if (conv_done_i) begin
          data_d[ch_q] = conv_data_i;
          rdy_d[ch_q]  = 1'b1;
          if (mode_q == SCAN_SINGLE) begin
            strobe_n_d = 1'b0;
            if (cont) go_in = 1'b1;
            else st_d = ST_SLEEP;
          end else if (nxt_found) begin
            ch_d   = nxt_ch;
            ord_d  = nxt_ord;
            go_pin = 1'b1;
            strobe_n_d = scan_setup_reg_i.ready_after_all_en;
          end else begin
            st_d = ST_SLEEP;
            strobe_n_d = 1'b0;
          end
        end
      end
      default: st_d = ST_STANDBY;
    endcase
    // channel entry: optional pin settle, then optional input settle
    if (go_pin) begin
      if (mode_d == SCAN_BIAS && scan_setup_reg_i.pin_settle_delay_en) begin
        st_d  = ST_PIN_WAIT;
        cnt_d = pin_load;
      end else begin
        go_in = 1'b1;
      end
    end
    if (go_in) begin
      if (scan_setup_reg_i.input_settle_delay_en) begin
        st_d  = ST_IN_WAIT;
        cnt_d = in_load;
      end else begin
        st_d    = ST_CONV;
        start_d = 1'b1;
      end
    end
    if (cmd_pd) begin
      start_d    = 1'b0;
      strobe_n_d = 1'b1;
      if (running) st_d = (pd_q == PD_STBY) ? ST_STANDBY : ST_SLEEP;
      else if (power_down_field_i == PD_STBY) st_d = ST_STANDBY;
      else if (power_down_field_i == PD_SLEEP) st_d = ST_SLEEP;
    end
    // status follows the state being entered
    case (st_d)
      ST_STANDBY: pstat_d = PSTAT_STBY;
      ST_SLEEP:   pstat_d = PSTAT_SLEEP;
      default:    pstat_d = PSTAT_RUN;
    endcase
  end

  // pin drive: sequencer owns pins only in the biased scan with sequencing on;
  // next-state values so the first channel's pin is up as its conversion starts
  always_comb begin
    pin_d = pin_direction_reg_i;
    if (mode_d == SCAN_BIAS && pin_sequencing_bit_i) begin
      pin_d = '0;
      if (st_d != ST_STANDBY && st_d != ST_SLEEP && channel_map_i[ch_d].channel_pin_enable)
        pin_d = PIN_N'(1) << channel_map_i[ch_d].channel_pin_map;
    end
  end

  // registers of the scan engine
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= ST_STANDBY;
      ch_q <= 3'h0;
      ord_q <= ORD_NONE;
      cnt_q <= '0;
      mode_q <= SCAN_SINGLE;
      pd_q <= PD_SLEEP;
      rate_q <= 4'h0;
      rdy_q <= '0;
      data_q <= '0;
      strobe_n_q <= 1'b1;
      start_q <= 1'b0;
      pstat_q <= PSTAT_STBY;
      pin_q <= '0;
      err_pin_q <= 1'b0;
      err_ord_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      ord_q <= ord_d;
      cnt_q <= cnt_d;
      mode_q <= mode_d;
      pd_q <= pd_d;
      rate_q <= rate_d;
      rdy_q <= rdy_d;
      data_q <= data_d;
      strobe_n_q <= strobe_n_d;
      start_q <= start_d;
      pstat_q <= pstat_d;
      pin_q <= pin_d;
      err_pin_q <= |pin_clash;
      err_ord_q <= |ord_bad;
    end
  end

  assign conv_start_o              = start_q;
  assign input_select_o            = ch_q;
  assign rate_o                    = rate_q;
  assign power_state_status_o      = pstat_q;
  assign per_channel_ready_flags_o = rdy_q;
  assign data_ready_strobe_n_o     = strobe_n_q;
  assign pin_conflict_error_o      = err_pin_q;
  assign order_error_o             = err_ord_q;
  assign bias_output_pin_o         = pin_q;
  assign channel_data_o            = data_q;

  // checks on the scan engine
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_PSTAT_IDLE: assert property (st_q == ST_STANDBY
    |-> power_state_status_o == PSTAT_STBY)
    else $error("standby not reported");
  AST_PSTAT_SLEEP: assert property (st_q == ST_SLEEP
    |-> power_state_status_o == PSTAT_SLEEP)
    else $error("sleep not reported");
  AST_PSTAT_RUN: assert property (running |-> power_state_status_o == PSTAT_RUN)
    else $error("running state not reported as 00");
  AST_SCAN_ENABLED: assert property (conv_start_o && mode_q != SCAN_SINGLE
    |-> channel_map_i[input_select_o].channel_enable_bit)
    else $error("disabled channel converted");
  AST_BAD_CFG: assert property (idle && cmd_seq && cfg_bad && !cmd_pd |=> idle)
    else $error("invalid configuration started a scan");
  AST_RDY_ALL: assert property (!data_ready_strobe_n_o && mode_q != SCAN_SINGLE
    && $past(scan_setup_reg_i.ready_after_all_en) |-> st_q == ST_SLEEP)
    else $error("ready strobe before scan end");
  AST_IN_DELAY: assert property (st_q == ST_IN_WAIT && cnt_q == '0 && !cmd_pd
    |=> conv_start_o && st_q == ST_CONV)
    else $error("conversion did not start after input delay");
  AST_READY_FLAG: assert property (st_q == ST_CONV && conv_done_i && !cmd_pd
    |=> per_channel_ready_flags_o[$past(ch_q)]
    && channel_data_o[$past(ch_q)] == $past(conv_data_i))
    else $error("result or ready flag not stored");
  AST_AUTO_SLEEP: assert property (st_q == ST_CONV && conv_done_i && mode_q != SCAN_SINGLE
    && !nxt_found && !cmd_pd |=> st_q == ST_SLEEP && power_state_status_o == PSTAT_SLEEP)
    else $error("scan did not end in sleep");
  AST_PD_ABORT: assert property (running && cmd_pd
    |=> !conv_start_o && st_q == (($past(pd_q) == PD_STBY) ? ST_STANDBY : ST_SLEEP))
    else $error("power-down did not abort scan");
  AST_PIN_DIRECT: assert property (mode_d != SCAN_BIAS
    |=> bias_output_pin_o == $past(pin_direction_reg_i))
    else $error("pins not following direction register");

  COV_SCAN_END: cover property (st_q == ST_CONV && mode_q == SCAN_MULTI ##1 st_q == ST_SLEEP);
  COV_BIAS_PIN: cover property (st_q == ST_PIN_WAIT ##[1:300] st_q == ST_CONV);
  COV_ABORT: cover property (running && cmd_pd);
endmodule : acss_sequencer

// ---- acss_pkg.sv ----
// Shared constants and types for the channel scan sequencer.
// Assumes a 40 MHz core clock and configuration held stable by the register file.
package acss_pkg;
  localparam int CH_N          = 6;
  localparam int PIN_N         = 6;
  localparam int DATA_W        = 24;
  localparam int CNT_W         = 24;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DELAY_UNIT_NS = 4000;
  localparam int DELAY_UNIT_CYC = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [1:0] CMD_TAG      = 2'h2;
  localparam logic [1:0] CMD_MODE_PD  = 2'h1;
  localparam logic [1:0] CMD_MODE_SEQ = 2'h3;
  localparam logic [1:0] SCAN_SINGLE  = 2'h0;
  localparam logic [1:0] SCAN_MULTI   = 2'h1;
  localparam logic [1:0] SCAN_BIAS    = 2'h2;
  localparam logic [1:0] SCAN_RSVD    = 2'h3;
  localparam logic [1:0] PSTAT_RUN    = 2'h0;
  localparam logic [1:0] PSTAT_SLEEP  = 2'h1;
  localparam logic [1:0] PSTAT_STBY   = 2'h2;
  localparam logic [1:0] PD_SLEEP     = 2'h1;
  localparam logic [1:0] PD_STBY      = 2'h2;
  localparam logic [2:0] ORD_BAD_LO   = 3'h0;
  localparam logic [2:0] ORD_BAD_HI   = 3'h7;
  localparam logic [2:0] ORD_NONE     = 3'h0;

  typedef struct packed {
    logic [1:0] tag;
    logic [1:0] mode;
    logic [3:0] rate;
  } acss_cmd_s;

  typedef struct packed {
    logic [2:0] channel_pin_map;
    logic [2:0] channel_order_field;
    logic       channel_enable_bit;
    logic       channel_pin_enable;
  } acss_chmap_s;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] input_select;
    logic       input_settle_delay_en;
    logic       pin_settle_delay_en;
    logic       ready_after_all_en;
  } acss_scan_setup_s;

  typedef logic [DATA_W-1:0] acss_data_t;
  typedef acss_chmap_s [CH_N-1:0] acss_chmap_t;
  typedef acss_data_t [CH_N-1:0] acss_data_arr_t;
  typedef enum logic [2:0] {ST_STANDBY, ST_SLEEP, ST_PIN_WAIT, ST_IN_WAIT, ST_CONV} acss_state_e;
endpackage : acss_pkg

// ---- acss_conv_model.sv ----
// Converter stand-in: answers a start with one done pulse carrying a result unless latency_i is zero or another start comes first.
// Assumes starts arrive on clock_i and the latency input holds through a conversion.
`timescale 1ns/100ps
module acss_conv_model (
  input  wire logic            clock_i,
  input  wire logic            conv_start_i,
  input  wire logic [2:0]      input_select_i,
  input  wire logic [7:0]      latency_i,
  output logic                 conv_done_o,
  output acss_pkg::acss_data_t conv_data_o
);
  import acss_pkg::*;
  logic [7:0] cnt_q;
  logic [2:0] ch_q;

  initial begin
    cnt_q       = 8'h00;
    ch_q        = 3'h0;
    conv_done_o = 1'b0;
    conv_data_o = 24'h000000;
  end

  // result names its channel; between pulses data toggles so stale data matches a new result only when the last one came from the same channel
  always @(posedge clock_i) begin
    conv_done_o <= 1'b0;
    conv_data_o <= ~conv_data_o;
    if (conv_start_i) begin
      cnt_q <= latency_i;
      ch_q  <= input_select_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        conv_done_o <= 1'b1;
        conv_data_o <= {21'h0C0DE5, ch_q};
      end
    end
  end
endmodule : acss_conv_model

// ---- tb_acss_sequencer.sv ----
// Self-checking bench for the scan sequencer with a converter model at the far side.
// Assumes commands on the link clock are spaced well beyond the synchroniser depth.
`timescale 1ns/100ps
module tb_acss_sequencer;
  import acss_pkg::*;
  localparam int DLY = 2;
  logic clock_i, rst_i, link_clk_i, link_rst_i, link_cmd_valid_i;
  logic [7:0] link_cmd_i, input_delay_i, pin_delay_i, lat;
  acss_scan_setup_s setup;
  acss_chmap_t chmap;
  logic scyc, cont, pin_seq, conv_done, conv_start, strobe_n, perr, oerr;
  logic [1:0] pd, pstat;
  logic [PIN_N-1:0] pin_dir, pins;
  acss_data_t conv_data;
  logic [2:0] sel;
  logic [3:0] rate;
  logic [CH_N-1:0] flags;
  acss_data_arr_t chdata;
  int errors, samples_checked, strobes, gap, min_gap;
  logic [2:0] seen_ch[$];
  logic [PIN_N-1:0] seen_pin[$];

  acss_sequencer #(.DLY_UNIT(DLY)) i_dut (.clock_i(clock_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i), .link_rst_i(link_rst_i), .link_cmd_i(link_cmd_i),
    .link_cmd_valid_i(link_cmd_valid_i), .scan_setup_reg_i(setup), .channel_map_i(chmap),
    .input_delay_i(input_delay_i), .pin_delay_i(pin_delay_i), .single_cycle_bit_i(scyc),
    .continuous_single_cycle_bit_i(cont), .power_down_field_i(pd),
    .pin_sequencing_bit_i(pin_seq), .pin_direction_reg_i(pin_dir), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .conv_start_o(conv_start), .input_select_o(sel), .rate_o(rate),
    .power_state_status_o(pstat), .per_channel_ready_flags_o(flags),
    .data_ready_strobe_n_o(strobe_n), .pin_conflict_error_o(perr), .order_error_o(oerr),
    .bias_output_pin_o(pins), .channel_data_o(chdata));
  acss_conv_model i_conv (.clock_i(clock_i), .conv_start_i(conv_start),
    .input_select_i(sel), .latency_i(lat), .conv_done_o(conv_done), .conv_data_o(conv_data));

  // clocks: core 25 ns, link 15 ns with an unrelated phase offset
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.7;
    forever #7.5 link_clk_i = ~link_clk_i;
  end

  // watches starts, done-to-start gaps, pins during conversion and strobes
  always @(posedge clock_i) begin
    gap <= conv_done ? 0 : gap + 1;
    if (conv_start === 1'b1) begin
      seen_ch.push_back(sel);
      if (gap < min_gap) min_gap <= gap;
    end
    if (conv_done === 1'b1) seen_pin.push_back(pins);
    if (strobe_n === 1'b0) strobes <= strobes + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic acss_chmap_s ce(input logic [2:0] pm, input logic [2:0] ord,
                                     input logic en, input logic pen);
    return '{pm, ord, en, pen};
  endfunction : ce

  // one command byte on the link, then spacing long enough for the next
  task automatic send_cmd(input logic [1:0] mode);
    @(posedge link_clk_i);
    #2;
    link_cmd_i = {CMD_TAG, mode, 4'hB};
    link_cmd_valid_i = 1'b1;
    @(posedge link_clk_i);
    #2;
    link_cmd_valid_i = 1'b0;
    repeat (8) @(posedge link_clk_i);
    @(posedge clock_i);
    #2;
  endtask : send_cmd

  task automatic start_scan();
    seen_ch.delete();
    seen_pin.delete();
    strobes = 0;
    min_gap = 1000;
    send_cmd(CMD_MODE_SEQ);
  endtask : start_scan

  task automatic wait_done();
    int n;
    n = 0;
    // sample off the edge; one more edge lets the monitor log the final strobe
    while (pstat === PSTAT_RUN && n < 3000) begin
      @(posedge clock_i);
      #2;
      n++;
    end
    @(posedge clock_i);
    #2;
    check("scan finished in time", n < 3000, 1'b1);
  endtask : wait_done

  task automatic t_reset();
    check("status after reset", pstat, PSTAT_STBY);
    check("strobe idle", strobe_n, 1'b1);
    check("flags after reset", flags, 6'h00);
  endtask : t_reset

  // plain scan: pin maps clash and one order is bad, neither may matter here
  task automatic t_plain();
    setup = '{SCAN_MULTI, 3'h0, 1'b1, 1'b0, 1'b0};
    chmap = '{default: '0};
    chmap[0] = ce(3'h5, 3'h3, 1'b1, 1'b1);
    chmap[1] = ce(3'h5, 3'h1, 1'b1, 1'b1);
    chmap[2] = ce(3'h5, 3'h2, 1'b1, 1'b1);
    chmap[3] = ce(3'h0, 3'h0, 1'b1, 1'b0);
    input_delay_i = 8'h05;
    cont = 1'b1;
    start_scan();
    check("status running", pstat, PSTAT_RUN);
    pin_dir = 6'h15;
    repeat (2) @(posedge clock_i);
    #2;
    check("pins from register", pins, 6'h15);
    wait_done();
    check("status end", pstat, PSTAT_SLEEP);
    check("visits", seen_ch.size(), 3);
    check("first", seen_ch[0], 3'h1);
    check("second", seen_ch[1], 3'h2);
    check("third", seen_ch[2], 3'h0);
    check("strobes each", strobes, 3);
    check("flags", flags, 6'h07);
    check("data ch1", chdata[1], {21'h0C0DE5, 3'h1});
    check("order error", oerr, 1'b1);
    check("pin conflict", perr, 1'b1);
    check("rate", rate, 4'hB);
    check("input delay", min_gap >= 5 * DLY, 1'b1);
    setup.ready_after_all_en = 1'b1;
    chmap = '{default: '0};
    chmap[4] = ce(3'h0, 3'h4, 1'b1, 1'b0);
    chmap[5] = ce(3'h1, 3'h2, 1'b1, 1'b0);
    start_scan();
    wait_done();
    check("strobe once", strobes, 1);
    check("flags cleared", flags, 6'h30);
    check("order ok", oerr, 1'b0);
  endtask : t_plain

  // biased scan: each channel lights only its mapped pin, after the pin delay
  task automatic t_bias();
    setup = '{SCAN_BIAS, 3'h0, 1'b0, 1'b1, 1'b0};
    chmap = '{default: '0};
    chmap[0] = ce(3'h2, 3'h3, 1'b1, 1'b1);
    chmap[1] = ce(3'h1, 3'h1, 1'b1, 1'b1);
    chmap[2] = ce(3'h0, 3'h2, 1'b1, 1'b1);
    pin_delay_i = 8'h03;
    pin_dir = 6'h3F;
    pin_seq = 1'b1;
    start_scan();
    wait_done();
    check("bias visits", seen_ch.size(), 3);
    check("bias first", seen_ch[0], 3'h1);
    check("pin ch1", seen_pin[0], 6'h02);
    check("pin ch2", seen_pin[1], 6'h01);
    check("pin ch0", seen_pin[2], 6'h04);
    check("pin delay", min_gap >= 3 * DLY, 1'b1);
    check("bias end", pstat, PSTAT_SLEEP);
    pin_seq = 1'b0;
    start_scan();
    check("register pins", pins, 6'h3F);
    wait_done();
  endtask : t_bias

  // refusals: pin clash blocks the biased scan, single-cycle zero blocks any scan but the single one
  task automatic t_refuse();
    chmap[2] = ce(3'h1, 3'h2, 1'b1, 1'b1);
    @(posedge clock_i);
    #2;
    check("clash flag", perr, 1'b1);
    start_scan();
    check("clash refused", pstat, PSTAT_SLEEP);
    chmap[2] = ce(3'h0, 3'h2, 1'b1, 1'b1);
    scyc = 1'b0;
    start_scan();
    check("cycle bit refused", pstat, PSTAT_SLEEP);
    scyc = 1'b1;
  endtask : t_refuse

  // abort into the state latched at start, then change the input and restart
  task automatic t_abort();
    lat = 8'hC8;
    pd = PD_STBY;
    setup.mode = SCAN_MULTI;
    start_scan();
    pd = PD_SLEEP;
    send_cmd(CMD_MODE_PD);
    check("abort state", pstat, PSTAT_STBY);
    send_cmd(CMD_MODE_PD);
    check("pd sleep", pstat, PSTAT_SLEEP);
    lat = 8'h04;
    setup = '{SCAN_SINGLE, 3'h4, 1'b0, 1'b0, 1'b0};
    cont = 1'b0;
    start_scan();
    wait_done();
    check("new input", seen_ch.size() > 0 && seen_ch[0] === 3'h4, 1'b1);
  endtask : t_abort

  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  initial begin
    #(25 * 30000);
    errors++;
    complete_run();
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    strobes = 0;
    gap = 0;
    min_gap = 1000;
    rst_i = 1'b1;
    link_rst_i = 1'b1;
    link_cmd_i = 8'h00;
    link_cmd_valid_i = 1'b0;
    setup = '{SCAN_MULTI, 3'h0, 1'b0, 1'b0, 1'b0};
    chmap = '{default: '0};
    input_delay_i = 8'h00;
    pin_delay_i = 8'h00;
    lat = 8'h04;
    scyc = 1'b1;
    cont = 1'b0;
    pd = PD_STBY;
    pin_seq = 1'b0;
    pin_dir = 6'h2A;
    repeat (20) @(posedge clock_i);
    #2;
    rst_i = 1'b0;
    link_rst_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #2;
    t_reset();
    t_plain();
    t_bias();
    t_refuse();
    t_abort();
    complete_run();
  end
endmodule : tb_acss_sequencer
